//--- ecra_pkg.sv
package ecra_pkg;

  // ===========================================================================
  // link addressing
  // ===========================================================================
  localparam logic [3:0] DEV_TYPE_CFG   = 4'hB;  // device type of the config register
  localparam int         DEV_TYPE_POS   = 4;     // device type field position
  localparam int         HW_ADDR_POS    = 1;     // hardware address field position
  localparam int         RW_POS         = 0;     // read/write bit position
  localparam int         WA0_A15_POS    = 7;     // word address byte 0, bit A15
  localparam int         WA0_A11_POS    = 3;     // word address byte 0, bit A11
  localparam int         WA0_A10_POS    = 2;     // word address byte 0, bit A10

  // ===========================================================================
  // configuration register layout
  // ===========================================================================
  localparam int         ECC_POS        = 7;     // ecc used flag in first data byte
  localparam int         SCHEME_POS     = 1;     // protection scheme select in first byte
  localparam int         LOCK_POS       = 0;     // lock bit in first byte
  localparam logic [7:0] CONFIRM_LOCK   = 8'h99; // confirmation when lock bit is one
  localparam logic [7:0] CONFIRM_OPEN   = 8'h66; // confirmation when lock bit is zero
  localparam logic [7:0] ZONE_RST       = 8'h00; // zone protect bits as delivered
  localparam logic       SCHEME_RST     = 1'b0;  // legacy pin protection as delivered
  localparam logic       LOCK_RST       = 1'b0;  // writable as delivered
  localparam int         WR_BYTES       = 3;     // data bytes of a legal write

  // ===========================================================================
  // array zoning
  // ===========================================================================
  localparam int         ZONES          = 8;     // number of protect zones
  localparam int         ZONE_BYTES     = 8192;  // bytes per zone
  localparam int         ZONE_SEL_POS   = 13;    // lowest address bit that selects a zone

  // ===========================================================================
  // pin synchroniser
  // ===========================================================================
  localparam int         SYNC_PINS      = 6;     // scl, sda, wp, three address straps
  localparam int         PIN_SCL        = 0;
  localparam int         PIN_SDA        = 1;
  localparam int         PIN_WP         = 2;
  localparam int         PIN_HWA        = 3;

  // ===========================================================================
  // types
  // ===========================================================================
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,  // waiting for a start
    ST_RX   = 3'b001,  // shifting in a byte
    ST_ACK  = 3'b011,  // driving acknowledge
    ST_TX   = 3'b010,  // shifting out a byte
    ST_HACK = 3'b110,  // sampling the host acknowledge
    ST_SKIP = 3'b100   // not addressed, wait for start or stop
  } ecra_state_e;

  typedef enum logic [1:0] {
    RX_DEV  = 2'b00,   // device address byte
    RX_WA0  = 2'b01,   // word address byte 0
    RX_WA1  = 2'b11,   // word address byte 1
    RX_DATA = 2'b10    // write data bytes
  } ecra_rxkind_e;

endpackage

//--- ecra_cfg_access.sv
// Function
// - eight independent zones of 8192 bytes each
// - protect bit n covers zone n addresses
// - set bit refuses zone writes; delivered zero
// - legacy mode ignores zone bits; filler byte
// - exactly three data bytes, else abort
// - confirmation 99h for lock, 66h otherwise
// - write-protect pin never blocks register writes
// - locked writes acknowledged, nothing changes
// - lock can never be cleared by a write, only by sys_rst
// - read needs word address; no current read
// - read returns byte0, byte1, then wraps
// - byte0 flags/mode/lock, byte1 zone bits
// - ecc flag follows the latest read
// - scheme one uses zones, zero uses pin
// - byte0 bit 0 is the permanent lock bit
module ecra_cfg_access
  import ecra_pkg::*;
(
  // clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    sys_rst,
  // two-wire link pins
  input  wire logic                    sclIn,
  input  wire logic                    sdaIn,
  output logic                         sdaOut,
  output logic                         sdaOe,
  // device pins
  input  wire logic                    wpPin,
  input  wire logic [2:0]              hwAddr,
  // array side, same clock
  input  wire logic                    arrayWrReq,
  input  wire logic [15:0]             arrayWrAddr,
  input  wire logic                    arrayReadDone,
  input  wire logic                    arrayEccUsed,
  // results
  output logic                         arrayWrAllowed,
  output logic [ZONES-1:0]             zoneProtectBits,
  output logic                         protectionSchemeSelect,
  output logic                         cfgLocked,
  output logic                         eccUsedFlag
);

  // ===========================================================================
  // pin synchronisers
  // ===========================================================================
  logic [SYNC_PINS-1:0] pinRaw;                 // all outside pins together
  logic [SYNC_PINS-1:0] pinClean_q;             // filtered pin levels

  assign pinRaw = {hwAddr, wpPin, sdaIn, sclIn};

  // three flops per pin, level taken once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_PINS; gi++) begin : g_sync
      logic s1_q, s2_q, s3_q;                   // synchroniser chain
      always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
          s1_q <= 1'b1;
          s2_q <= 1'b1;
          s3_q <= 1'b1;
          pinClean_q[gi] <= 1'b1;
        end else begin
          s1_q <= pinRaw[gi];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) begin               // stable, accept
            pinClean_q[gi] <= s3_q;
          end
        end
      end
    end
  endgenerate

  // ===========================================================================
  // link events
  // ===========================================================================
  logic sclPrev_q, sdaPrev_q;                   // previous filtered levels
  logic sclRise, sclFall, startEv, stopEv;      // decoded link events
  logic sclNow, sdaNow;                         // filtered levels now

  assign sclNow  = pinClean_q[PIN_SCL];
  assign sdaNow  = pinClean_q[PIN_SDA];
  assign sclRise = sclNow & ~sclPrev_q;
  assign sclFall = ~sclNow & sclPrev_q;
  assign startEv = sclNow & sclPrev_q & sdaPrev_q & ~sdaNow;
  assign stopEv  = sclNow & sclPrev_q & ~sdaPrev_q & sdaNow;

  // edge history
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
    end else begin
      sclPrev_q <= sclNow;
      sdaPrev_q <= sdaNow;
    end
  end

  // ===========================================================================
  // helpers
  // ===========================================================================
  // device address byte addresses this register
  function automatic logic devMatch(input logic [7:0] b, input logic [2:0] hw);
    devMatch = (b[DEV_TYPE_POS +: 4] == DEV_TYPE_CFG) && (b[HW_ADDR_POS +: 3] == hw);
  endfunction

  // word address byte 0 selects this register
  function automatic logic waMatch(input logic [7:0] b);
    waMatch = b[WA0_A15_POS] & b[WA0_A11_POS] & ~b[WA0_A10_POS];
  endfunction

  // ===========================================================================
  // link state
  // ===========================================================================
  ecra_state_e  state_q;                        // byte level state
  ecra_rxkind_e rxKind_q;                       // what the current rx byte is
  logic [3:0]   bitCnt_q;                       // bits shifted in this byte
  logic [7:0]   shift_q;                        // rx and tx shift register
  logic         busFree_q;                      // last sequence ended with stop
  logic         addrValid_q;                    // word address received, no data yet
  logic         readByte_q;                     // next read byte index
  logic         hostAck_q;                      // host acknowledged last byte
  logic [2:0]   dataCnt_q;                      // write data bytes received
  logic [7:0]   wrByte0_q, wrByte1_q, wrConf_q; // captured write bytes
  logic         sdaOe_q;                        // drive sda low
  logic [7:0]   cfgByte0, cfgByte1;             // readback images

  // first byte carries flag, scheme and lock; second the zones
  assign cfgByte0 = {eccUsedFlag, 5'h00, protectionSchemeSelect, cfgLocked};
  assign cfgByte1 = zoneProtectBits;

  // byte protocol engine
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q     <= ST_IDLE;
      rxKind_q    <= RX_DEV;
      bitCnt_q    <= 4'h0;
      shift_q     <= 8'h00;
      busFree_q   <= 1'b1;
      addrValid_q <= 1'b0;
      readByte_q  <= 1'b0;
      hostAck_q   <= 1'b0;
      dataCnt_q   <= 3'h0;
      wrByte0_q   <= 8'h00;
      wrByte1_q   <= 8'h00;
      wrConf_q    <= 8'h00;
      sdaOe_q     <= 1'b0;
    end else if (stopEv) begin
      // stop ends everything and frees the bus
      state_q     <= ST_IDLE;
      busFree_q   <= 1'b1;
      addrValid_q <= 1'b0;
      sdaOe_q     <= 1'b0;
    end else if (startEv) begin
      // only after a stop, or a repeated start after our word address
      state_q   <= (busFree_q || addrValid_q) ? ST_RX : ST_SKIP;
      rxKind_q  <= RX_DEV;
      bitCnt_q  <= 4'h0;
      busFree_q <= 1'b0;
      dataCnt_q <= 3'h0;                        // a restart aborts a write
      sdaOe_q   <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE, ST_SKIP: begin
          sdaOe_q <= 1'b0;
        end
        ST_RX: begin
          if (sclRise) begin                    // sample data bit
            shift_q  <= {shift_q[6:0], sdaNow};
            bitCnt_q <= bitCnt_q + 4'h1;
          end else if (sclFall && bitCnt_q == 4'h8) begin
            bitCnt_q <= 4'h0;
            unique case (rxKind_q)
              RX_DEV: begin
                if (!devMatch(shift_q, pinClean_q[PIN_HWA +: 3])) begin
                  state_q <= ST_SKIP;
                end else if (!shift_q[RW_POS]) begin // write: word address next
                  state_q  <= ST_ACK;
                  sdaOe_q  <= 1'b1;
                  rxKind_q <= RX_WA0;
                end else if (addrValid_q) begin // random read only
                  state_q    <= ST_ACK;
                  sdaOe_q    <= 1'b1;
                  readByte_q <= 1'b0;
                end else begin                  // current address read refused
                  state_q <= ST_SKIP;
                end
              end
              RX_WA0: begin
                if (waMatch(shift_q)) begin
                  state_q  <= ST_ACK;
                  sdaOe_q  <= 1'b1;
                  rxKind_q <= RX_WA1;
                end else begin
                  state_q <= ST_SKIP;
                end
              end
              RX_WA1: begin                     // low address bits are don't care
                state_q     <= ST_ACK;
                sdaOe_q     <= 1'b1;
                rxKind_q    <= RX_DATA;
                addrValid_q <= 1'b1;
                dataCnt_q   <= 3'h0;
              end
              RX_DATA: begin                    // every byte acknowledged
                state_q     <= ST_ACK;
                sdaOe_q     <= 1'b1;
                addrValid_q <= 1'b0;
                if (dataCnt_q == 3'h0) wrByte0_q <= shift_q;
                if (dataCnt_q == 3'h1) wrByte1_q <= shift_q; // filler in legacy
                if (dataCnt_q == 3'h2) wrConf_q  <= shift_q;
                if (dataCnt_q != 3'h7) dataCnt_q <= dataCnt_q + 3'h1;
              end
            endcase
          end
        end
        ST_ACK: begin
          if (sclFall) begin                    // acknowledge bit ends
            if (rxKind_q == RX_DEV) begin       // read: drive first byte
              state_q  <= ST_TX;
              shift_q  <= cfgByte0;
              sdaOe_q  <= ~cfgByte0[7];
              bitCnt_q <= 4'h0;
              readByte_q <= 1'b1;
            end else begin
              state_q <= ST_RX;
              sdaOe_q <= 1'b0;
            end
          end
        end
        ST_TX: begin
          if (sclFall) begin
            if (bitCnt_q == 4'h7) begin         // byte out, release for host ack
              state_q <= ST_HACK;
              sdaOe_q <= 1'b0;
            end else begin
              shift_q  <= {shift_q[6:0], 1'b0};
              sdaOe_q  <= ~shift_q[6];
              bitCnt_q <= bitCnt_q + 4'h1;
            end
          end
        end
        ST_HACK: begin
          if (sclRise) begin
            hostAck_q <= ~sdaNow;
          end else if (sclFall) begin
            if (hostAck_q) begin                // next byte, wrapping
              state_q    <= ST_TX;
              shift_q    <= readByte_q ? cfgByte1 : cfgByte0;
              sdaOe_q    <= readByte_q ? ~cfgByte1[7] : ~cfgByte0[7];
              bitCnt_q   <= 4'h0;
              readByte_q <= ~readByte_q;
            end else begin
              state_q <= ST_SKIP;
            end
          end
        end
      endcase
    end
  end

  // ===========================================================================
  // configuration register
  // ===========================================================================
  logic commit;                                 // legal write completes at stop
  logic confOk;                                 // confirmation matches lock bit

  assign confOk = wrByte0_q[LOCK_POS] ? (wrConf_q == CONFIRM_LOCK)
                                      : (wrConf_q == CONFIRM_OPEN);
  // no write-protect pin term here on purpose
  assign commit = stopEv && state_q != ST_SKIP && rxKind_q == RX_DATA
                  && dataCnt_q == 3'(WR_BYTES) && confOk && !cfgLocked;

  // register bits, delivered state zero
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      zoneProtectBits        <= ZONE_RST;
      protectionSchemeSelect <= SCHEME_RST;
      cfgLocked              <= LOCK_RST;
    end else if (commit) begin
      zoneProtectBits        <= wrByte1_q;
      protectionSchemeSelect <= wrByte0_q[SCHEME_POS];
      cfgLocked              <= cfgLocked | wrByte0_q[LOCK_POS];
    end
  end

  // ecc flag tracks the most recent array read
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      eccUsedFlag <= 1'b0;
    end else if (arrayReadDone) begin
      eccUsedFlag <= arrayEccUsed;
    end
  end

  // ===========================================================================
  // array write gate
  // ===========================================================================
  // zone scheme uses bit addr[15:13]; legacy uses the pin
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      arrayWrAllowed <= 1'b0;
    end else if (arrayWrReq) begin
      if (protectionSchemeSelect) begin
        arrayWrAllowed <= ~zoneProtectBits[arrayWrAddr[ZONE_SEL_POS +: 3]];
      end else begin                            // zones ignored
        arrayWrAllowed <= ~pinClean_q[PIN_WP];
      end
    end
  end

  // ===========================================================================
  // pin drivers
  // ===========================================================================
  // open drain: the pin is only ever pulled low
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sdaOut <= 1'b0;
      sdaOe  <= 1'b0;
    end else begin
      sdaOut <= 1'b0;
      sdaOe  <= sdaOe_q;
    end
  end

endmodule

//--- ecra_cfg_chk.sv
module ecra_cfg_chk
  import ecra_pkg::*;
(
  // clock and reset
  input wire logic             sys_clk,
  input wire logic             sys_rst,
  // link and device pins
  input wire logic             sclIn,
  input wire logic             sdaIn,
  input wire logic             sdaOut,
  input wire logic             sdaOe,
  input wire logic             wpPin,
  input wire logic [2:0]       hwAddr,
  // array side
  input wire logic             arrayWrReq,
  input wire logic [15:0]      arrayWrAddr,
  input wire logic             arrayReadDone,
  input wire logic             arrayEccUsed,
  // results
  input wire logic             arrayWrAllowed,
  input wire logic [ZONES-1:0] zoneProtectBits,
  input wire logic             protectionSchemeSelect,
  input wire logic             cfgLocked,
  input wire logic             eccUsedFlag
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // ==========================================================================
  // helper counters
  // ==========================================================================
  logic [3:0] sdaLowRun_q;  // cycles with data pin low
  logic [3:0] sclHighRun_q; // cycles with link clock high
  logic [3:0] wpRun_q;      // cycles with protect pin unchanged
  logic       wpPrev_q;     // protect pin one cycle ago
  logic       zoneAllow;    // zone bit of the requested address, inverted
  assign zoneAllow = ~zoneProtectBits[arrayWrAddr[15:13]];
  // run of low data pin, saturating
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) sdaLowRun_q <= 4'h0;
    else if (sdaIn) sdaLowRun_q <= 4'h0;
    else if (sdaLowRun_q != 4'hF) sdaLowRun_q <= sdaLowRun_q + 4'h1;
  end
  // run of high link clock, saturating
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) sclHighRun_q <= 4'h0;
    else if (!sclIn) sclHighRun_q <= 4'h0;
    else if (sclHighRun_q != 4'hF) sclHighRun_q <= sclHighRun_q + 4'h1;
  end
  // run of steady protect pin, saturating
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wpPrev_q <= 1'b0;
      wpRun_q  <= 4'h0;
    end else begin
      wpPrev_q <= wpPin;
      if (wpPin != wpPrev_q) wpRun_q <= 4'h0;
      else if (wpRun_q != 4'hF) wpRun_q <= wpRun_q + 4'h1;
    end
  end
  // ==========================================================================
  // assertions
  // ==========================================================================
  zone_gate_a: assert property (arrayWrReq && protectionSchemeSelect |=>
    arrayWrAllowed == $past(zoneAllow)) else $error("zone gate answer wrong");
  pin_gate_a: assert property (arrayWrReq && !protectionSchemeSelect
    && wpRun_q >= 4'h8 |=> arrayWrAllowed == !$past(wpPin)) else $error("pin gate answer wrong");
  gate_hold_a: assert property (!arrayWrReq |=> $stable(arrayWrAllowed))
    else $error("gate answer moved without request");
  ecc_load_a: assert property (arrayReadDone |=> eccUsedFlag == $past(arrayEccUsed))
    else $error("ecc flag not loaded");
  ecc_hold_a: assert property (!arrayReadDone |=> $stable(eccUsedFlag))
    else $error("ecc flag moved without read");
  lock_sticky_a: assert property (cfgLocked |=> cfgLocked)
    else $error("lock cleared");
  lock_freeze_a: assert property (cfgLocked |=> $stable(zoneProtectBits) &&
    $stable(protectionSchemeSelect)) else $error("locked register changed");
  commit_stop_a: assert property (sdaLowRun_q >= 4'hA |=> $stable(zoneProtectBits) &&
    $stable(cfgLocked) && $stable(protectionSchemeSelect)) else $error("commit without stop");
  drive_steady_a: assert property (sclHighRun_q >= 4'h8 |=> $stable(sdaOe))
    else $error("data drive moved while clock high");
  drive_low_a: assert property ($rose(sdaOe) |-> !sclIn)
    else $error("data drive began while clock high");
endmodule

//--- ecra_host_model.sv
module ecra_host_model (
  // clock and observed line
  input wire logic sys_clk,
  input wire logic sdaLine,
  // driven pins
  output logic     sclPin,
  output logic     sdaRel
);
  timeunit 1ns;
  timeprecision 100ps;
  // bus idle, both lines released
  initial begin
    sclPin = 1'b1;
    sdaRel = 1'b1;
  end
  // wait whole clock cycles
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // one bit: 16 cycles low, 16 high, sample at end of high
  task automatic bitIo(input logic b, output logic r);
    sdaRel <= b;
    cyc(8);
    sclPin <= 1'b1;
    cyc(16);
    r = sdaLine;
    sclPin <= 1'b0;
    cyc(8);
  endtask
  // start or repeated start without a stop before it
  task automatic start();
    sdaRel <= 1'b1;
    cyc(8);
    sclPin <= 1'b1;
    cyc(8);
    sdaRel <= 1'b0;
    cyc(8);
    sclPin <= 1'b0;
    cyc(8);
  endtask
  // every sequence is closed by a stop
  task automatic stop();
    sdaRel <= 1'b0;
    cyc(8);
    sclPin <= 1'b1;
    cyc(8);
    sdaRel <= 1'b1;
    cyc(16);
  endtask
  // eight bits out or in, then the ninth bit
  task automatic xbyte(input logic [7:0] d, input logic hb, output logic [7:0] r,
                       output logic a);
    logic v;
    for (int i = 7; i >= 0; i--) begin
      bitIo(d[i], v);
      r[i] = v;
    end
    bitIo(hb, v);
    a = ~v;
  endtask
endmodule

//--- tb_eeprom_config_register_access.sv
module tb_eeprom_config_register_access
  import ecra_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [2:0] HW   = 3'h5;                       // strap value
  localparam logic [7:0] DEVW = {DEV_TYPE_CFG, HW, 1'b0};
  logic sys_clk, sys_rst, wpPin, arrayWrReq, arrayReadDone, arrayEccUsed;
  logic [2:0]       hwAddr;
  logic [15:0]      arrayWrAddr;
  logic             sdaOut, sdaOe, arrayWrAllowed, protectionSchemeSelect, cfgLocked;
  logic             eccUsedFlag, hostRel;
  logic [ZONES-1:0] zoneProtectBits;
  logic [7:0]       expB0, expB1; // expected register bytes
  wire              sclLine;
  wire              sdaLine = hostRel & (~sdaOe | sdaOut); // pull-up, open drain drives sdaOut
  int               errorCnt, checked;
  // ==========================================================================
  // design and far side
  // ==========================================================================
  ecra_cfg_access uut (.sys_clk, .sys_rst, .sclIn(sclLine), .sdaIn(sdaLine), .sdaOut,
    .sdaOe, .wpPin, .hwAddr, .arrayWrReq, .arrayWrAddr, .arrayReadDone, .arrayEccUsed,
    .arrayWrAllowed, .zoneProtectBits, .protectionSchemeSelect, .cfgLocked, .eccUsedFlag);
  ecra_host_model host (.sys_clk, .sdaLine, .sclPin(sclLine), .sdaRel(hostRel));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // ==========================================================================
  // tasks
  // ==========================================================================
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string s);
    checked++;
    if (got !== exp) begin
      errorCnt++;
      $display("[FAIL] %0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask
  task automatic done(input string s);
    $display("test %s finished, %0d errors", s, errorCnt);
  endtask
  task automatic printVerdict();
    $display("checks %0d errors %0d", checked, errorCnt);
    if (errorCnt == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // register outputs against the expected bytes
  task automatic regChk();
    chk(zoneProtectBits, expB1, "zones");
    chk({6'h00, protectionSchemeSelect, cfgLocked}, {6'h00, expB0[1:0]}, "mode");
  endtask
  // write: w = {byte0, byte1, confirmation, count}
  task automatic cfgWr(input logic [31:0] w);
    logic [7:0] r;
    logic       a, ok;
    host.start();
    host.xbyte(DEVW, 1'b1, r, ok);
    host.xbyte(8'h88, 1'b1, r, a);
    ok &= a;
    host.xbyte(8'h00, 1'b1, r, a);
    ok &= a;
    for (int i = 0; i < int'(w[7:0]); i++) begin
      host.xbyte(i < 3 ? w[31-8*i -: 8] : 8'h5A, 1'b1, r, a);
      ok &= a;
    end
    chk({7'h00, ok}, 8'h01, "write acks");
    host.stop();
    repeat (16) @(posedge sys_clk);
    // commit only: three bytes, matching confirmation, not locked
    if (w[7:0] == 8'd3 && !expB0[0] && w[15:8] == (w[24] ? CONFIRM_LOCK : CONFIRM_OPEN)) begin
      expB0[1:0] = w[25:24];
      expB1 = w[23:16];
    end
    regChk();
  endtask
  // random read, n data bytes, nack on the last
  task automatic rdChk(input int n);
    logic [7:0] r;
    logic       a, ok;
    host.start();
    host.xbyte(DEVW, 1'b1, r, ok);
    host.xbyte(8'h88, 1'b1, r, a);
    ok &= a;
    host.xbyte(8'h00, 1'b1, r, a);
    ok &= a;
    host.start();
    host.xbyte(DEVW | 8'h01, 1'b1, r, a);
    ok &= a;
    chk({7'h00, ok}, 8'h01, "read acks");
    for (int i = 0; i < n; i++) begin
      host.xbyte(8'hFF, i == n - 1, r, a);
      chk(r, i[0] ? expB1 : expB0, "read data");
    end
    host.stop();
  endtask
  // addressing that must be refused: {device byte, word byte 0}
  task automatic probe(input logic [15:0] p);
    logic [7:0] r;
    logic       a;
    host.start();
    host.xbyte(p[15:8], 1'b1, r, a);
    if (a && !p[8]) host.xbyte(p[7:0], 1'b1, r, a);
    host.stop();
    chk({7'h00, a}, 8'h00, "refused ack");
  endtask
  task automatic gate(input logic [15:0] ad, input logic ex);
    @(posedge sys_clk);
    arrayWrReq  <= 1'b1;
    arrayWrAddr <= ad;
    @(posedge sys_clk);
    arrayWrReq <= 1'b0;
    #1 chk({7'h00, arrayWrAllowed}, {7'h00, ex}, "gate");
  endtask
  task automatic ecc(input logic v);
    @(posedge sys_clk);
    arrayReadDone <= 1'b1;
    arrayEccUsed  <= v;
    @(posedge sys_clk);
    arrayReadDone <= 1'b0;
    #1 chk({7'h00, eccUsedFlag}, {7'h00, v}, "ecc flag");
  endtask
  // ==========================================================================
  // tests
  // ==========================================================================
  initial begin
    logic [15:0] pr[4];
    logic [31:0] ab[4];
    pr = '{{DEVW[7:4], ~HW, 1'b0, 8'h88}, {DEVW, 8'h8C}, {DEVW, 8'h08}, {DEVW | 8'h01, 8'h00}};
    ab = '{32'h023C_9903, 32'h033C_6603, 32'h023C_6602, 32'h023C_6604};
    sys_rst = 1'b1;
    wpPin = 1'b1;
    hwAddr = HW;
    arrayWrReq = 1'b0;
    arrayWrAddr = 16'h0000;
    arrayReadDone = 1'b0;
    arrayEccUsed = 1'b0;
    expB0 = 8'h00;
    expB1 = 8'h00;
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (8) @(posedge sys_clk);
    regChk();
    rdChk(2);
    done("reset");
    cfgWr({8'h02, 8'hA5, CONFIRM_OPEN, 8'd3});
    rdChk(4);
    done("write");
    for (int z = 0; z < ZONES; z++) begin
      gate({z[2:0], 13'h0000}, ~expB1[z]);
      gate({z[2:0], 13'h1FFF}, ~expB1[z]);
    end
    done("zones");
    foreach (ab[k]) cfgWr(ab[k]);
    done("abort");
    foreach (pr[k]) probe(pr[k]);
    done("refuse");
    cfgWr({8'h00, 8'hFF, CONFIRM_OPEN, 8'd3});
    gate(16'h4000, 1'b0);
    @(posedge sys_clk) wpPin <= 1'b0;
    repeat (8) @(posedge sys_clk);
    gate(16'h4000, 1'b1);
    done("legacy");
    ecc(1'b1);
    expB0[7] = 1'b1;
    rdChk(2);
    ecc(1'b0);
    expB0[7] = 1'b0;
    done("ecc");
    cfgWr({8'h03, 8'h0F, CONFIRM_LOCK, 8'd3});
    cfgWr({8'h02, 8'h00, CONFIRM_OPEN, 8'd3});
    rdChk(2);
    done("lock");
    printVerdict();
  end
  // watchdog well past the expected run
  initial begin
    repeat (60000) @(posedge sys_clk);
    errorCnt++;
    $display("[FAIL] %0t watchdog expired", $time);
    printVerdict();
  end
endmodule
bind ecra_cfg_access ecra_cfg_chk chk_i (.sys_clk, .sys_rst, .sclIn, .sdaIn, .sdaOut, .sdaOe,
  .wpPin, .hwAddr, .arrayWrReq, .arrayWrAddr, .arrayReadDone, .arrayEccUsed, .arrayWrAllowed,
  .zoneProtectBits, .protectionSchemeSelect, .cfgLocked, .eccUsedFlag);
